// ===== verilog/sci_pkg.sv
package sci_pkg;

  // ************************************************************
  // Serial timing
  // ************************************************************
  localparam int CLOCK_HZ = 20_000_000;
  localparam int BAUD_RATE = 4800;
  // Nearest whole cycle count for one bit period
  localparam int BIT_CYCLES = (CLOCK_HZ + BAUD_RATE / 2) / BAUD_RATE;
  localparam int CNT_W = 16;
  localparam int DATA_BITS = 8;

  // ************************************************************
  // Command and reply characters
  // ************************************************************
  localparam logic [7:0] CH_BSLASH = 8'h5c;
  localparam logic [7:0] CH_OPEN = 8'h56;
  localparam logic [7:0] CH_WIDTH = 8'h48;
  localparam logic [7:0] CH_LOC = 8'h4a;
  localparam logic [7:0] CH_WRITE = 8'h4e;
  localparam logic [7:0] CH_READ = 8'h4d;
  localparam logic [7:0] CH_GET_LOC = 8'h49;
  localparam logic [7:0] CH_GET_WIDTH = 8'h47;
  localparam logic [7:0] CH_RESET = 8'h57;
  localparam logic [7:0] CH_QUERY = 8'h51;
  localparam logic [7:0] CH_EXIT = 8'h58;
  localparam logic [7:0] CH_ERROR = 8'h21;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_NINE = 8'h39;
  localparam logic [7:0] CH_THREE = 8'h33;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_F = 8'h46;
  localparam logic [7:0] CH_LO_A = 8'h61;
  localparam logic [7:0] CH_LO_F = 8'h66;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SPACE = 8'h20;
  // OR-ing this into an upper-case command gives its reply letter
  localparam logic [7:0] CH_LOWER = 8'h20;

  // ************************************************************
  // Session values
  // ************************************************************
  localparam logic [9:0] WIDTH_MIN = 10'h080;
  localparam logic [9:0] WIDTH_MAX = 10'h09f;
  localparam logic [9:0] LOC_MAX = 10'h01f;
  localparam logic [7:0] WIDTH_RESET = 8'h80;
  localparam logic [4:0] LOC_RESET = 5'h00;
  localparam logic [1:0] NODE_RESET = 2'h0;
  localparam int BUF_DEPTH = 4;
  localparam int REPLY_DEPTH = 5;

endpackage : sci_pkg

// ===== verilog/serial_rx.sv
module serial_rx #(
  parameter int CYCLES_PER_BIT = sci_pkg::BIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic rx_line,
  output logic [7:0] rx_data,
  output logic rx_valid
);
  import sci_pkg::*;

  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;

  rx_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;

  wire bit_end = (cnt_q == CNT_W'(CYCLES_PER_BIT - 1));
  wire half_end = (cnt_q == CNT_W'(CYCLES_PER_BIT / 2 - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      bit_q <= 3'h0;
      shift_q <= 8'h00;
      rx_data <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      cnt_q <= cnt_q + CNT_W'(1);
      case (state_q)
        RX_IDLE: begin
          cnt_q <= '0;
          if (!rx_line) begin
            state_q <= RX_START;
          end
        end
        // Start bit is checked at its middle, so later samples land mid-bit
        RX_START: begin
          if (half_end) begin
            cnt_q <= '0;
            bit_q <= 3'h0;
            state_q <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (bit_end) begin
            cnt_q <= '0;
            shift_q <= {rx_line, shift_q[7:1]};
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'(DATA_BITS - 1)) begin
              state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (bit_end) begin
            state_q <= RX_IDLE;
            // Framing error drops the character
            if (rx_line) begin
              rx_data <= shift_q;
              rx_valid <= 1'b1;
            end
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

endmodule : serial_rx

// ===== verilog/serial_tx.sv
module serial_tx #(
  parameter int CYCLES_PER_BIT = sci_pkg::BIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic tx_line
);
  import sci_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_q;
  logic [9:0] frame_q;

  wire bit_end = (cnt_q == CNT_W'(CYCLES_PER_BIT - 1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      frame_q <= 10'h3ff;
      tx_busy <= 1'b0;
      tx_line <= 1'b1;
    end else if (!tx_busy) begin
      cnt_q <= '0;
      bit_q <= 4'h0;
      tx_line <= 1'b1;
      if (tx_start) begin
        // Stop bit, data LSB first, start bit
        frame_q <= {1'b1, tx_data, 1'b0};
        tx_busy <= 1'b1;
      end
    end else begin
      tx_line <= frame_q[0];
      cnt_q <= cnt_q + CNT_W'(1);
      if (bit_end) begin
        cnt_q <= '0;
        frame_q <= {1'b1, frame_q[9:1]};
        bit_q <= bit_q + 4'h1;
        if (bit_q == 4'(DATA_BITS + 1)) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end

endmodule : serial_tx

// ===== verilog/serial_command_interpreter.sv
module serial_command_interpreter #(
  parameter int CYCLES_PER_BIT = sci_pkg::BIT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_rx_line,
  input wire logic jumper_a_closed,
  input wire logic jumper_b_closed,
  input wire logic [7:0] reg_rdata,
  output logic serial_tx_line,
  output logic [4:0] reg_addr_q,
  output logic [7:0] reg_wdata_q,
  output logic reg_we_q,
  output logic session_q
);
  import sci_pkg::*;

  typedef enum {ST_LISTEN, ST_FETCH, ST_SEND} state_e;

  // ************************************************************
  // Serial line
  // ************************************************************
  logic [7:0] rx_data;
  logic rx_valid;
  logic tx_busy;
  logic tx_start_q, tx_start_d;
  logic [7:0] tx_data_q, tx_data_d;

  serial_rx #(.CYCLES_PER_BIT(CYCLES_PER_BIT)) u_rx (
    .clock(clock),
    .rst_n(rst_n),
    .rx_line(serial_rx_line),
    .rx_data(rx_data),
    .rx_valid(rx_valid)
  );

  serial_tx #(.CYCLES_PER_BIT(CYCLES_PER_BIT)) u_tx (
    .clock(clock),
    .rst_n(rst_n),
    .tx_start(tx_start_q),
    .tx_data(tx_data_q),
    .tx_busy(tx_busy),
    .tx_line(serial_tx_line)
  );

  // ************************************************************
  // State
  // ************************************************************
  state_e state_q, state_d;
  logic session_d;
  logic [1:0] node_q;
  logic [1:0] open_step_q, open_step_d;
  logic open_match_q, open_match_d;
  logic [7:0] buf_q [BUF_DEPTH];
  logic [7:0] buf_d [BUF_DEPTH];
  logic [2:0] buf_cnt_q, buf_cnt_d;
  logic buf_ovf_q, buf_ovf_d;
  logic all_dec_q, all_dec_d;
  logic [9:0] dec_acc_q, dec_acc_d;
  logic [7:0] hex_acc_q, hex_acc_d;
  logic [7:0] width_q, width_d;
  logic [4:0] loc_q, loc_d;
  logic [4:0] offset_q, offset_d;
  logic [7:0] rep_q [REPLY_DEPTH];
  logic [7:0] rep_d [REPLY_DEPTH];
  logic [2:0] rep_len_q, rep_len_d;
  logic [2:0] rep_idx_q, rep_idx_d;
  logic [4:0] reg_addr_d;
  logic [7:0] reg_wdata_d;
  logic reg_we_d;

  // ************************************************************
  // Character decode
  // ************************************************************
  function automatic logic [7:0] hex_char(input logic [3:0] nib);
    hex_char = (nib < 4'ha) ? (CH_ZERO + {4'h0, nib}) : (CH_UP_A + {4'h0, nib} - 8'h0a);
  endfunction : hex_char

  wire is_digit = (rx_data >= CH_ZERO) && (rx_data <= CH_NINE);
  wire is_up_hex = (rx_data >= CH_UP_A) && (rx_data <= CH_UP_F);
  wire is_lo_hex = (rx_data >= CH_LO_A) && (rx_data <= CH_LO_F);
  wire is_hex = is_digit || is_up_hex || is_lo_hex;
  wire is_blank = (rx_data == CH_CR) || (rx_data == CH_LF) || (rx_data == CH_SPACE);
  wire [7:0] hex_sub = is_digit ? CH_ZERO : (is_up_hex ? (CH_UP_A - 8'h0a) : (CH_LO_A - 8'h0a));
  wire [7:0] hex_val8 = rx_data - hex_sub;
  wire [3:0] hex_val = hex_val8[3:0];
  wire [9:0] dec_next = 10'((dec_acc_q * 10'd10) + {6'h00, hex_val});
  wire [7:0] reply_letter = rx_data | CH_LOWER;

  wire dec_ok = (buf_cnt_q != 3'h0) && (buf_cnt_q <= 3'h3) && all_dec_q && !buf_ovf_q;
  wire hex_ok = (buf_cnt_q == 3'h2) && !buf_ovf_q;
  wire buf_empty = (buf_cnt_q == 3'h0) && !buf_ovf_q;

  wire [4:0] access_addr = loc_q + offset_q;
  wire [4:0] offset_next = (offset_q == width_q[4:0]) ? 5'h00 : (offset_q + 5'h01);

  // Decimal digits of the value returned by I or G
  wire [7:0] dec_src = (rx_data == CH_GET_WIDTH) ? width_q : {3'h0, loc_q};
  wire [7:0] dec_h = dec_src / 8'd100;
  wire [7:0] dec_t = (dec_src / 8'd10) % 8'd10;
  wire [7:0] dec_o = dec_src % 8'd10;

  wire tx_free = !tx_busy && !tx_start_q;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_d = state_q;
    session_d = session_q;
    open_step_d = open_step_q;
    open_match_d = open_match_q;
    buf_d = buf_q;
    buf_cnt_d = buf_cnt_q;
    buf_ovf_d = buf_ovf_q;
    all_dec_d = all_dec_q;
    dec_acc_d = dec_acc_q;
    hex_acc_d = hex_acc_q;
    width_d = width_q;
    loc_d = loc_q;
    offset_d = offset_q;
    rep_d = rep_q;
    rep_len_d = rep_len_q;
    rep_idx_d = rep_idx_q;
    reg_addr_d = reg_addr_q;
    reg_wdata_d = reg_wdata_q;
    reg_we_d = 1'b0;
    tx_start_d = 1'b0;
    tx_data_d = tx_data_q;
    case (state_q)
      ST_LISTEN: begin
        if (rx_valid && !session_q) begin
          open_step_d = 2'h0;
          if (rx_data == CH_BSLASH) begin
            open_step_d = 2'h1;
          end else if (open_step_q == 2'h1 && is_digit) begin
            open_step_d = 2'h2;
            open_match_d = (rx_data <= CH_THREE) && (rx_data[1:0] == node_q);
          end else if (open_step_q == 2'h2 && rx_data == CH_OPEN && open_match_q) begin
            session_d = 1'b1;
            offset_d = 5'h00;
            rep_d[0] = reply_letter;
            rep_len_d = 3'h1;
            state_d = ST_SEND;
          end
          buf_cnt_d = 3'h0;
          buf_ovf_d = 1'b0;
          all_dec_d = 1'b1;
          dec_acc_d = 10'h000;
        end else if (rx_valid && is_hex) begin
          // Operand characters are collected and parsed as they arrive
          if (buf_cnt_q < 3'(BUF_DEPTH)) begin
            buf_d[buf_cnt_q[1:0]] = rx_data;
            buf_cnt_d = buf_cnt_q + 3'h1;
          end else begin
            buf_ovf_d = 1'b1;
          end
          all_dec_d = all_dec_q && is_digit;
          if (is_digit) begin
            dec_acc_d = dec_next;
          end
          hex_acc_d = {hex_acc_q[3:0], hex_val};
        end else if (rx_valid && !is_blank) begin
          // A terminator ends the command; Q alone keeps the buffer
          if (rx_data != CH_QUERY) begin
            buf_cnt_d = 3'h0;
            buf_ovf_d = 1'b0;
            all_dec_d = 1'b1;
            dec_acc_d = 10'h000;
          end
          state_d = ST_SEND;
          rep_d[0] = CH_ERROR;
          rep_len_d = 3'h1;
          case (rx_data)
            CH_WIDTH: begin
              if (dec_ok && dec_acc_q >= WIDTH_MIN && dec_acc_q <= WIDTH_MAX) begin
                width_d = dec_acc_q[7:0];
                offset_d = 5'h00;
                rep_d[0] = reply_letter;
              end
            end
            CH_LOC: begin
              if (dec_ok && dec_acc_q <= LOC_MAX) begin
                loc_d = dec_acc_q[4:0];
                offset_d = 5'h00;
                rep_d[0] = reply_letter;
              end
            end
            CH_WRITE: begin
              if (hex_ok) begin
                reg_addr_d = access_addr;
                reg_wdata_d = hex_acc_q;
                reg_we_d = 1'b1;
                offset_d = offset_next;
                rep_d[0] = reply_letter;
              end
            end
            CH_READ: begin
              if (buf_empty) begin
                reg_addr_d = access_addr;
                offset_d = offset_next;
                state_d = ST_FETCH;
              end
            end
            CH_GET_LOC, CH_GET_WIDTH: begin
              if (buf_empty) begin
                if (dec_src >= 8'd100) begin
                  rep_d[0] = CH_ZERO + dec_h;
                  rep_d[1] = CH_ZERO + dec_t;
                  rep_d[2] = CH_ZERO + dec_o;
                  rep_d[3] = reply_letter;
                  rep_len_d = 3'h4;
                end else if (dec_src >= 8'd10) begin
                  rep_d[0] = CH_ZERO + dec_t;
                  rep_d[1] = CH_ZERO + dec_o;
                  rep_d[2] = reply_letter;
                  rep_len_d = 3'h3;
                end else begin
                  rep_d[0] = CH_ZERO + dec_o;
                  rep_d[1] = reply_letter;
                  rep_len_d = 3'h2;
                end
              end
            end
            CH_RESET: begin
              if (buf_empty) begin
                session_d = 1'b0;
                width_d = WIDTH_RESET;
                loc_d = LOC_RESET;
                offset_d = 5'h00;
                open_step_d = 2'h0;
                state_d = ST_LISTEN;
              end
            end
            CH_QUERY: begin
              for (int k = 0; k < BUF_DEPTH; k++) begin
                if (3'(k) < buf_cnt_q) begin
                  rep_d[k] = buf_q[k];
                end
              end
              rep_d[buf_cnt_q] = reply_letter;
              rep_len_d = buf_cnt_q + 3'h1;
            end
            CH_EXIT: begin
              if (buf_empty) begin
                session_d = 1'b0;
                open_step_d = 2'h0;
                rep_d[0] = reply_letter;
              end
            end
            default: begin
            end
          endcase
        end
        rep_idx_d = 3'h0;
      end
      ST_FETCH: begin
        rep_d[0] = hex_char(reg_rdata[7:4]);
        rep_d[1] = hex_char(reg_rdata[3:0]);
        rep_d[2] = CH_READ | CH_LOWER;
        rep_len_d = 3'h3;
        state_d = ST_SEND;
      end
      ST_SEND: begin
        if (tx_free) begin
          if (rep_idx_q == rep_len_q) begin
            state_d = ST_LISTEN;
          end else begin
            tx_start_d = 1'b1;
            tx_data_d = rep_q[rep_idx_q];
            rep_idx_d = rep_idx_q + 3'h1;
          end
        end
      end
      default: state_d = ST_LISTEN;
    endcase
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_LISTEN;
      session_q <= 1'b0;
      node_q <= NODE_RESET;
      open_step_q <= 2'h0;
      open_match_q <= 1'b0;
      buf_cnt_q <= 3'h0;
      buf_ovf_q <= 1'b0;
      all_dec_q <= 1'b1;
      dec_acc_q <= 10'h000;
      hex_acc_q <= 8'h00;
      width_q <= WIDTH_RESET;
      loc_q <= LOC_RESET;
      offset_q <= 5'h00;
      rep_len_q <= 3'h0;
      rep_idx_q <= 3'h0;
      reg_addr_q <= 5'h00;
      reg_wdata_q <= 8'h00;
      reg_we_q <= 1'b0;
      tx_start_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      state_q <= state_d;
      session_q <= session_d;
      node_q <= {jumper_a_closed, jumper_b_closed};
      open_step_q <= open_step_d;
      open_match_q <= open_match_d;
      buf_cnt_q <= buf_cnt_d;
      buf_ovf_q <= buf_ovf_d;
      all_dec_q <= all_dec_d;
      dec_acc_q <= dec_acc_d;
      hex_acc_q <= hex_acc_d;
      width_q <= width_d;
      loc_q <= loc_d;
      offset_q <= offset_d;
      rep_len_q <= rep_len_d;
      rep_idx_q <= rep_idx_d;
      reg_addr_q <= reg_addr_d;
      reg_wdata_q <= reg_wdata_d;
      reg_we_q <= reg_we_d;
      tx_start_q <= tx_start_d;
      tx_data_q <= tx_data_d;
    end
  end

  // Character stores carry no control meaning and need no reset
  for (genvar g = 0; g < REPLY_DEPTH; g++) begin : g_store
    always_ff @(posedge clock) begin
      rep_q[g] <= rep_d[g];
    end
    if (g < BUF_DEPTH) begin : g_buf
      always_ff @(posedge clock) begin
        buf_q[g] <= buf_d[g];
      end
    end
  end

endmodule : serial_command_interpreter

// ===== tb/sci_assertions.sv
module sci_checker #(
  parameter int CYCLES_PER_BIT = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic serial_rx_line,
  input wire logic jumper_a_closed,
  input wire logic jumper_b_closed,
  input wire logic [7:0] reg_rdata,
  input wire logic serial_tx_line,
  input wire logic [4:0] reg_addr_q,
  input wire logic [7:0] reg_wdata_q,
  input wire logic reg_we_q,
  input wire logic session_q
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] FRAME_END = 16'(10 * CYCLES_PER_BIT - 1);
  localparam logic [15:0] STOP_MID = 16'(9 * CYCLES_PER_BIT + CYCLES_PER_BIT / 2);
  localparam logic [15:0] QUIET = 16'(14 * CYCLES_PER_BIT);
  logic [15:0] frame_q;
  logic [15:0] frame_d;
  logic [15:0] quiet_q;
  logic [15:0] quiet_d;
  logic frame_on;

  // ************************************************************
  // Helper counters
  // ************************************************************
  // Position inside the outgoing frame, zero while idle
  assign frame_on = (frame_q != 16'h0 || !serial_tx_line) && frame_q != FRAME_END;
  assign frame_d = frame_on ? frame_q + 16'h1 : 16'h0;
  // Cycles with the session closed and the input line idle
  assign quiet_d = (session_q || !serial_rx_line) ? 16'h0 :
                   (quiet_q == QUIET) ? QUIET : quiet_q + 16'h1;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_q <= 16'h0;
      quiet_q <= 16'h0;
    end else begin
      frame_q <= frame_d;
      quiet_q <= quiet_d;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_we_pulse; reg_we_q |=> !reg_we_q; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe too long");
  property p_we_session; reg_we_q |-> session_q; endproperty
  a_we_session: assert property (p_we_session) else $error("write while closed");
  property p_we_reply; reg_we_q |-> ##[0:4] !serial_tx_line; endproperty
  a_we_reply: assert property (p_we_reply) else $error("write not confirmed");
  property p_wdata_cause; $changed(reg_wdata_q) |-> reg_we_q; endproperty
  a_wdata_cause: assert property (p_wdata_cause) else $error("write data moved");
  property p_open_reply; $rose(session_q) |-> ##[0:8] !serial_tx_line; endproperty
  a_open_reply: assert property (p_open_reply) else $error("open not answered");
  property p_start_len; $fell(serial_tx_line) |-> (!serial_tx_line) [*8]; endproperty
  a_start_len: assert property (p_start_len) else $error("start bit short");
  property p_stop_bit; frame_q == STOP_MID |-> serial_tx_line; endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop bit low");
  property p_quiet_closed; quiet_q == QUIET |-> serial_tx_line; endproperty
  a_quiet_closed: assert property (p_quiet_closed) else $error("reply while closed");

  c_write: cover property (reg_we_q);
  c_open: cover property ($rose(session_q));
  c_close: cover property ($fell(session_q));
endmodule : sci_checker

// ===== tb/host_model.sv
module host_model #(
  parameter int CPB = 16
) (
  input wire logic clock,
  input wire logic tx_from_dut,
  output logic rx_to_dut
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sh;

  // ************************************************************
  // Serial sender and receiver
  // ************************************************************
  initial rx_to_dut = 1'b1;

  task automatic send(input string s);
    logic [9:0] f;
    for (int i = 0; i < s.len(); i++) begin
      f = {1'b1, 8'(s[i]), 1'b0};
      for (int b = 0; b < 10; b++) begin
        rx_to_dut <= f[b];
        repeat (CPB) @(posedge clock);
      end
    end
  endtask : send

  initial forever begin
    @(negedge tx_from_dut);
    repeat (CPB / 2) @(posedge clock);
    for (int b = 0; b < 8; b++) begin
      repeat (CPB) @(posedge clock);
      sh = {tx_from_dut, sh[7:1]};
    end
    repeat (CPB) @(posedge clock);
    got.push_back(sh);
  end

  // Waits for n reply characters, or watches for silence when n is zero
  task automatic get(input int n, output logic [31:0] r);
    int t;
    t = 0;
    r = 32'h0;
    while ((n == 0 || got.size() < n) && t < (n == 0 ? 14 : 60) * CPB) begin
      @(posedge clock);
      t++;
    end
    repeat (2 * CPB) @(posedge clock);
    if (got.size() != n) r = 32'hffffffff;
    else while (got.size() > 0) r = {r[23:0], got.pop_front()};
  endtask : get
endmodule : host_model

// ===== tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CPB = 16;
  logic clock = 1'b0;
  logic rst_n, rx, jmp_a, jmp_b, tx, we, sess;
  logic [4:0] addr;
  logic [7:0] wdata, rdata;
  logic [7:0] regs [32];
  logic [31:0] r;
  int fail_count, cmp_count, cyc, writes;

  always #25 clock = ~clock;

  serial_command_interpreter #(.CYCLES_PER_BIT(CPB)) DUT (
    .clock(clock), .rst_n(rst_n), .serial_rx_line(rx), .jumper_a_closed(jmp_a),
    .jumper_b_closed(jmp_b), .reg_rdata(rdata), .serial_tx_line(tx), .reg_addr_q(addr),
    .reg_wdata_q(wdata), .reg_we_q(we), .session_q(sess));
  host_model #(.CPB(CPB)) host (.clock(clock), .tx_from_dut(tx), .rx_to_dut(rx));

  assign rdata = regs[addr];
  always @(posedge clock) begin
    if (we) begin
      regs[addr] <= wdata;
      writes++;
    end
  end

  // ************************************************************
  // Checking and commands
  // ************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done

  // Sends a command and compares the packed reply, zero meaning silence
  task automatic cmd(input string s, input logic [31:0] exp);
    int n;
    n = 0;
    for (int i = 0; i < 4; i++) if (exp[8*i+:8] != 8'h00) n++;
    host.send(s);
    host.get(n, r);
    check(r, exp);
  endtask : cmd

  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      test_done();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_closed();
    cmd("M", 32'h0);
    cmd("\\1V", 32'h0);
    check({31'h0, sess}, 32'h0);
    $display("t_closed done");
  endtask : t_closed

  task automatic t_nodes();
    string s;
    s = "\\0V";
    for (int n = 0; n < 4; n++) begin
      {jmp_a, jmp_b} <= 2'(n);
      repeat (2) @(posedge clock);
      s[1] = 8'h30 + 8'(n ^ 1);
      cmd(s, 32'h0);
      s[1] = 8'h30 + 8'(n);
      cmd(s, "v");
      check({31'h0, sess}, 32'h1);
      cmd("X", "x");
      check({31'h0, sess}, 32'h0);
    end
    {jmp_a, jmp_b} <= 2'b00;
    repeat (2) @(posedge clock);
    $display("t_nodes done");
  endtask : t_nodes

  task automatic t_fields();
    cmd("\\0V", "v");
    cmd("131H", "h");
    cmd("G", "131g");
    cmd("30J", "j");
    cmd("I", "30i");
    cmd("32J", "!");
    cmd("160H", "!");
    cmd("127H", "!");
    cmd("1aJ", "!");
    cmd("Z", "!");
    cmd("I", "30i");
    cmd("G", "131g");
    cmd("159H", "h");
    cmd("0J", "j");
    cmd("I", "0i");
    cmd("12Q", "12q");
    cmd(" Q", "12q");
    cmd("Z", "!");
    cmd("1W", "!");
    check({31'h0, sess}, 32'h1);
    $display("t_fields done");
  endtask : t_fields

  task automatic t_rw();
    cmd("5N", "!");
    cmd("30J", "j");
    cmd("129H", "h");
    cmd("a5N", "n");
    cmd("3CN", "n");
    check({24'h0, regs[30]}, 32'ha5);
    check({24'h0, regs[31]}, 32'h3c);
    check(32'(writes), 32'h2);
    cmd("M", "A5m");
    cmd("M", "3Cm");
    $display("t_rw done");
  endtask : t_rw

  task automatic t_reset();
    cmd("W", 32'h0);
    check({31'h0, sess}, 32'h0);
    cmd("G", 32'h0);
    cmd("\\0V", "v");
    cmd("G", "128g");
    cmd("I", "0i");
    cmd("X", "x");
    $display("t_reset done");
  endtask : t_reset

  initial begin
    rst_n = 1'b0;
    jmp_a = 1'b0;
    jmp_b = 1'b0;
    for (int i = 0; i < 32; i++) regs[i] = 8'h00;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    t_closed();
    t_nodes();
    t_fields();
    t_rw();
    t_reset();
    test_done();
  end
endmodule : tb_top

bind serial_command_interpreter sci_checker #(.CYCLES_PER_BIT(CYCLES_PER_BIT)) u_chk (
  .clock(clock), .rst_n(rst_n), .serial_rx_line(serial_rx_line),
  .jumper_a_closed(jumper_a_closed), .jumper_b_closed(jumper_b_closed),
  .reg_rdata(reg_rdata), .serial_tx_line(serial_tx_line), .reg_addr_q(reg_addr_q),
  .reg_wdata_q(reg_wdata_q), .reg_we_q(reg_we_q), .session_q(session_q));
